/* pos_clock_front.v */
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "pos_map.vh"

module pos_clock_front #(
   parameter INST_DIV    = `POS_INST_DIV,
   parameter TIMER_WIDTH = 16,
   parameter DIV_WIDTH   = 8
) (
   input  wire        clk,
   input  wire        rst,
   // Wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Supply detector and reset pin
   input  wire        supply_ok,
   input  wire        reset_pin_n,
   // Factory option bits
   input  wire        osc_select_msb,
   input  wire        osc_select_mid,
   input  wire        osc_select_lsb,
   // Oscillator output pin sensed as an input
   input  wire        osc_drive_pin_in,
   // Results
   output reg         int_reset,
   output reg  [4:0]  osc_mode,
   output reg         osc_bias_enable,
   output reg         osc_drive_enable,
   output reg         osc_input_used,
   output reg         port_g_input_bit7,
   output reg         halt_control_in,
   output reg         inst_cycle_en,
   output wire        cpu_clk_en
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function [4:0] pos_decode;
      input [2:0] sel;
      begin
         if (sel[`POS_SEL_EXT_BIT])
            pos_decode = `POS_MODE_EXT;
         else
            case (sel)
               `POS_SEL_RC:    pos_decode = `POS_MODE_RC;
               `POS_SEL_RCR:   pos_decode = `POS_MODE_RCR;
               `POS_SEL_XT_NB: pos_decode = `POS_MODE_XT_NB;
               `POS_SEL_XT_B:  pos_decode = `POS_MODE_XT_B;
               default:        pos_decode = `POS_MODE_EXT;
            endcase
      end
   endfunction

   function pos_is_crystal;
      input [4:0] mode;
      begin
         pos_is_crystal = (mode == `POS_MODE_XT_NB) ||
                          (mode == `POS_MODE_XT_B);
      end
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam [TIMER_WIDTH-1:0] TIMER_ONE = {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
   localparam [3:0]             INST_ONE  = 4'h1;
   localparam [31:0]            INST_LAST_W = INST_DIV - 1;
   localparam [3:0]             INST_LAST = INST_LAST_W[3:0];

   reg  [2:0]             osc_sel;
   reg                    supply_seen;
   reg                    por_busy;
   reg                    por_done;
   reg  [TIMER_WIDTH-1:0] idle_timer;
   reg  [3:0]             inst_count;
   reg                    ext_sync1;
   reg                    ext_sync2;
   reg  [DIV_WIDTH-1:0]   cpu_clock_divider;

   reg                    next_por_busy;
   reg                    next_por_done;
   reg  [4:0]             next_mode;
   wire                   por_start;
   wire                   timer_underflow;
   wire                   ext_reset;
   wire                   wb_req;
   wire [2:0]             sel_code;

   assign sel_code  = {osc_select_msb, osc_select_mid,
                       osc_select_lsb};
   assign ext_reset = ~ext_sync2;
   // Rising edge of the detector output only
   assign por_start = supply_ok & ~supply_seen & ~por_done;
   assign timer_underflow = inst_cycle_en &
                            (idle_timer == `POS_TIMER_ZERO);
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // ---------------------------------------------------------------
   // Oscillator option decode
   // ---------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst)
         osc_sel <= `POS_SEL_RC;
      else
         osc_sel <= sel_code;
   end

   always @* begin
      next_mode = pos_decode(osc_sel);
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_mode          <= `POS_MODE_RC;
         osc_bias_enable   <= 1'b0;
         osc_drive_enable  <= 1'b0;
         osc_input_used    <= 1'b0;
         port_g_input_bit7 <= 1'b0;
         halt_control_in   <= 1'b0;
      end else begin
         osc_mode         <= next_mode;
         osc_bias_enable  <= (next_mode == `POS_MODE_XT_B);
         osc_drive_enable <= pos_is_crystal(next_mode);
         // Internal RC leaves the input pin floating
         osc_input_used   <= (next_mode != `POS_MODE_RC);
         if (pos_is_crystal(next_mode)) begin
            port_g_input_bit7 <= 1'b0;
            halt_control_in   <= 1'b0;
         end else begin
            port_g_input_bit7 <= osc_drive_pin_in;
            halt_control_in   <= osc_drive_pin_in;
         end
      end
   end

   // ---------------------------------------------------------------
   // External reset synchroniser
   // ---------------------------------------------------------------
   // Reset during a brownout depends on the pin being driven low
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
      end else begin
         ext_sync1 <= reset_pin_n;
         ext_sync2 <= ext_sync1;
      end
   end

   // ---------------------------------------------------------------
   // Instruction cycle enable
   // ---------------------------------------------------------------
   // Restarted at power-on so the 256-cycle hold is exact
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         inst_count    <= 4'h0;
         inst_cycle_en <= 1'b0;
      end else if (por_start) begin
         inst_count    <= 4'h0;
         inst_cycle_en <= 1'b0;
      end else if (inst_count == INST_LAST) begin
         inst_count    <= 4'h0;
         inst_cycle_en <= 1'b1;
      end else begin
         inst_count    <= inst_count + INST_ONE;
         inst_cycle_en <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Idle timer and power-on sequencer
   // ---------------------------------------------------------------
   always @* begin
      next_por_busy = por_busy;
      next_por_done = por_done;
      if (!supply_ok) begin
         // Supply lost: allow a new power-on sequence
         next_por_busy = 1'b0;
         next_por_done = 1'b0;
      end else if (por_start) begin
         next_por_busy = 1'b1;
      end else if (por_busy && timer_underflow) begin
         next_por_busy = 1'b0;
         next_por_done = 1'b1;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         supply_seen <= 1'b0;
         por_busy    <= 1'b0;
         por_done    <= 1'b0;
         idle_timer  <= `POS_TIMER_WRAP;
      end else begin
         supply_seen <= supply_ok;
         por_busy    <= next_por_busy;
         por_done    <= next_por_done;
         if (por_start)
            idle_timer <= `POS_POR_PRELOAD;
         else if (inst_cycle_en)
            idle_timer <= idle_timer - TIMER_ONE;
      end
   end

   // ---------------------------------------------------------------
   // Combined internal reset
   // ---------------------------------------------------------------
   // Both sources feed one flop, so they act identically
   always @(posedge clk or posedge rst) begin
      if (rst)
         int_reset <= 1'b1;
      else
         int_reset <= next_por_busy | ext_reset;
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Only the divider is cleared; no RAM state lives here
   always @(posedge clk or posedge rst) begin
      if (rst)
         cpu_clock_divider <= `POS_DIV_RESET;
      else if (int_reset)
         cpu_clock_divider <= `POS_DIV_RESET;
      else if (wb_req && wb_we_i && wb_sel_i[0] &&
               (wb_adr_i == `POS_ADR_DIV))
         cpu_clock_divider <= wb_dat_i[DIV_WIDTH-1:0];
   end

   // ---------------------------------------------------------------
   // Wishbone answer
   // ---------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `POS_ADR_DIV:
                  wb_dat_o[DIV_WIDTH-1:0] <= cpu_clock_divider;
               `POS_ADR_STAT: begin
                  wb_dat_o[`POS_ST_SEL_HI:`POS_ST_SEL_LO] <= osc_sel;
                  wb_dat_o[`POS_ST_POR_BUSY] <= por_busy;
                  wb_dat_o[`POS_ST_EXT_RST]  <= ext_reset;
                  wb_dat_o[`POS_ST_POR_DONE] <= por_done;
                  wb_dat_o[`POS_ST_INT_RST]  <= int_reset;
               end
               default:
                  wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // CPU clock prescaler
   // ---------------------------------------------------------------
   pos_prescaler #(
      .WIDTH     (DIV_WIDTH)
   ) u_prescaler (
      .clk       (clk),
      .rst       (rst),
      .clr       (int_reset),
      .div_value (cpu_clock_divider),
      .tick      (cpu_clk_en)
   );

endmodule

/* pos_clock_front_sva.sv */
`timescale 1ns/10ps
module pos_clock_front_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       supply_ok,
   input wire logic       reset_pin_n,
   input wire logic       osc_select_msb,
   input wire logic       osc_select_mid,
   input wire logic       osc_select_lsb,
   input wire logic       osc_drive_pin_in,
   input wire logic [31:0] wb_dat_o,
   input wire logic       wb_ack_o,
   input wire logic       int_reset,
   input wire logic [4:0] osc_mode,
   input wire logic       osc_bias_enable,
   input wire logic       osc_drive_enable,
   input wire logic       osc_input_used,
   input wire logic       port_g_input_bit7,
   input wire logic       cpu_clk_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_ext_wins: assert property (osc_select_msb
      && $past(osc_select_msb) && $past(osc_select_msb, 2)
      |-> osc_mode == 5'h10) else $error("external mode not chosen");
   a_rc_all_zero: assert property ({osc_select_msb, osc_select_mid,
      osc_select_lsb} == 3'h0 && $stable({osc_select_msb,
      osc_select_mid, osc_select_lsb}) && $past(osc_select_msb) == 1'b0
      |=> osc_mode == 5'h01 && !osc_input_used)
      else $error("internal RC not chosen");
   a_xtal_drive: assert property (osc_drive_enable ==
      (osc_mode[2] | osc_mode[3]) && osc_bias_enable == osc_mode[3])
      else $error("drive or bias wrong");
   // Drive low in two samples: the copy was taken in a released mode
   a_pin_release: assert property (!$past(rst)
      && !osc_drive_enable ##1 !osc_drive_enable
      |-> port_g_input_bit7 == $past(osc_drive_pin_in))
      else $error("pin not released");
   a_ext_reset: assert property ($fell(reset_pin_n)
      |-> ##3 int_reset) else $error("pin reset not applied");
   a_por_hold: assert property ($rose(supply_ok)
      |-> ##2 int_reset[*8]) else $error("power-on reset not held");
   a_div_stop: assert property (int_reset && $past(int_reset)
      |-> !cpu_clk_en) else $error("cpu clock ran in reset");
   a_div_cleared: assert property ($fell(int_reset)
      |=> cpu_clk_en ##1 cpu_clk_en) else $error("divider not cleared");
endmodule

bind pos_clock_front pos_clock_front_chk u_chk (
   .clk               (clk),
   .rst               (rst),
   .wb_cyc_i          (wb_cyc_i),
   .wb_stb_i          (wb_stb_i),
   .supply_ok         (supply_ok),
   .reset_pin_n       (reset_pin_n),
   .osc_select_msb    (osc_select_msb),
   .osc_select_mid    (osc_select_mid),
   .osc_select_lsb    (osc_select_lsb),
   .osc_drive_pin_in  (osc_drive_pin_in),
   .wb_dat_o          (wb_dat_o),
   .wb_ack_o          (wb_ack_o),
   .int_reset         (int_reset),
   .osc_mode          (osc_mode),
   .osc_bias_enable   (osc_bias_enable),
   .osc_drive_enable  (osc_drive_enable),
   .osc_input_used    (osc_input_used),
   .port_g_input_bit7 (port_g_input_bit7),
   .cpu_clk_en        (cpu_clk_en)
);

/* pos_map.vh */
`ifndef POS_MAP_VH
`define POS_MAP_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define POS_ADR_DIV      8'h00
`define POS_ADR_STAT     8'h04

// ---------------------------------------------------------------
// Reset values and preload figures
// ---------------------------------------------------------------
`define POS_DIV_RESET    8'h00
`define POS_POR_PRELOAD  16'h00FF
`define POS_TIMER_WRAP   16'hFFFF
`define POS_TIMER_ZERO   16'h0000
`define POS_INST_DIV     10

// ---------------------------------------------------------------
// Oscillator selection codes {msb, mid, lsb}
// ---------------------------------------------------------------
`define POS_SEL_RC       3'h0
`define POS_SEL_RCR      3'h1
`define POS_SEL_XT_NB    3'h2
`define POS_SEL_XT_B     3'h3
`define POS_SEL_EXT_BIT  2

// ---------------------------------------------------------------
// One-hot oscillator modes
// ---------------------------------------------------------------
`define POS_MODE_RC      5'h01
`define POS_MODE_RCR     5'h02
`define POS_MODE_XT_NB   5'h04
`define POS_MODE_XT_B    5'h08
`define POS_MODE_EXT     5'h10

// ---------------------------------------------------------------
// Status register field positions
// ---------------------------------------------------------------
`define POS_ST_SEL_LO    0
`define POS_ST_SEL_HI    2
`define POS_ST_POR_BUSY  3
`define POS_ST_EXT_RST   4
`define POS_ST_POR_DONE  5
`define POS_ST_INT_RST   6

`endif

/* pos_osc_partner.sv */
`timescale 1ns/10ps
// ---------------------------------------------
// Oscillator source and reset pin driver
// ---------------------------------------------
module pos_osc_partner (
   input  wire logic clk,
   input  wire logic hold_low,
   output logic      reset_pin_n,
   output logic      osc_drive_pin_in
);
   // Pulled up to supply unless the system pulls it down
   assign reset_pin_n = !hold_low;
   logic pin_level = 1'b0;
   // Undriven pin: pattern changes every cycle, no stale level
   always @(posedge clk) begin
      pin_level <= !pin_level;
   end
   assign osc_drive_pin_in = pin_level;
endmodule

/* pos_prescaler.v */
`timescale 1ns/10ps

module pos_prescaler #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             clr,
   input  wire [WIDTH-1:0] div_value,
   output reg              tick
);

   reg [WIDTH-1:0] count;

   // ---------------------------------------------------------------
   // Down counter, reloaded only when a period ends
   // ---------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= {WIDTH{1'b0}};
         tick  <= 1'b0;
      end else if (clr) begin
         count <= {WIDTH{1'b0}};
         tick  <= 1'b0;
      end else if (count == {WIDTH{1'b0}}) begin
         // New ratio taken here only: no shortened period
         count <= div_value;
         tick  <= 1'b1;
      end else begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
         tick  <= 1'b0;
      end
   end

endmodule

/* tb_por_osc_select_prescaler.sv */
`timescale 1ns/10ps
module tb_por_osc_select_prescaler;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sup = 0, hold = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, rd, dout;
   logic [2:0]  sel = 3'h0;
   logic [4:0]  mode;
   logic ack, ir, pin, rpn, bias, drv, used, g7, halt, inst, cen;
   int err_total = 0, compares = 0;
   always #12.5 clk = !clk;
   pos_osc_partner PTR (.clk(clk), .hold_low(hold), .reset_pin_n(rpn),
      .osc_drive_pin_in(pin));
   pos_clock_front #(.INST_DIV(4)) DUT (.clk(clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dout), .wb_ack_o(ack),
      .supply_ok(sup), .reset_pin_n(rpn), .osc_select_msb(sel[2]),
      .osc_select_mid(sel[1]), .osc_select_lsb(sel[0]),
      .osc_drive_pin_in(pin), .int_reset(ir), .osc_mode(mode),
      .osc_bias_enable(bias), .osc_drive_enable(drv),
      .osc_input_used(used), .port_g_input_bit7(g7),
      .halt_control_in(halt), .inst_cycle_en(inst), .cpu_clk_en(cen));
   task report_and_stop;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
      // No local limit: the watchdog ends a hung bus as a failure
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = dout;
      cyc <= 0; stb <= 0; we <= 0;
   endtask
   task wait_ir(input logic v, output int n);
      n = 0;
      while (ir !== v) begin
         @(posedge clk);
         n++;
      end
   endtask
   task t_modes;
      logic [4:0] e;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk) sel <= c[2:0];
         repeat (4) @(posedge clk);
         e = 5'h01 << (c[2] ? 4 : c[1:0]);
         chk("mode", mode, e);
         chk("drive", drv, e[2] | e[3]);
         chk("used", used, e != 5'h01);
         chk("bias", bias, e[3]);
         if (e[2] | e[3]) chk("g7", {g7, halt}, 2'b00);
         else chk("g7 copy", {g7, halt}, {!pin, !pin});
      end
   endtask
   task t_por;
      int n;
      @(posedge clk) sup <= 1;
      wait_ir(1, n);
      wb(1, 8'h00, 32'h5A);
      wait_ir(0, n);
      chk("por len", n > 1010 && n < 1036, 1);
      wb(0, 8'h00, 0);
      chk("div in por", rd, 0);
      repeat (300) @(posedge clk);
      chk("no repeat", ir, 0);
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (inst !== 1'b1);
      end
      chk("inst period", n, 4);
   endtask
   task t_div(input logic [7:0] v);
      int n;
      wb(1, 8'h00, {24'h0, v});
      wb(0, 8'h00, 0);
      chk("div rd", rd, {24'h0, v});
      repeat (3) begin
         do begin
            @(posedge clk);
         end while (cen !== 1'b1);
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cen !== 1'b1);
      chk("period", n, v + 1);
   endtask
   task t_pin;
      int n;
      @(posedge clk) hold <= 1;
      wait_ir(1, n);
      repeat (5) @(posedge clk);
      @(posedge clk) hold <= 0;
      wait_ir(0, n);
      chk("pin rst", n < 10, 1);
      wb(0, 8'h00, 0);
      chk("div clr", rd, 0);
      wb(0, 8'h40, 0);
      chk("unmapped", rd, 0);
   endtask
   task t_brown;
      int n;
      @(posedge clk) begin
         sup  <= 0;
         hold <= 1;
      end
      repeat (8) @(posedge clk);
      chk("brown rst", ir, 1);
      @(posedge clk) begin
         sup  <= 1;
         hold <= 0;
      end
      wait_ir(0, n);
      chk("new por", n > 1010 && n < 1036, 1);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      t_modes;
      t_por;
      t_div(8'h00);
      t_div(8'h03);
      t_div(8'hFF);
      t_pin;
      t_brown;
      report_and_stop;
   end
   initial begin
      #(25 * 20000);
      err_total++;
      report_and_stop;
   end
endmodule
